//--- design/tmc_period_timer.sv
// Purpose: Down-counter that times one measurement period.
// Assumes: Start and abort come from logic on the same clock.
// Notes:   A start while running reloads the full period.
`timescale 1ns/100ps
`include "tmc_map.svh"

module tmc_period_timer
    import tmc_pkg::*;
#(
    parameter logic [`TMC_TIMER_W-1:0] PERIOD_CYCLES = `TMC_TIMER_W'(`TMC_MEAS_CYCLES)
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // Control
    input  wire logic start_in,
    input  wire logic abort_in,
    // Status
    output logic      running_out,
    output logic      done_out
);

    logic [`TMC_TIMER_W-1:0] count_reg;
    logic [`TMC_TIMER_W-1:0] count_next;
    logic                    run_reg;
    logic                    run_next;
    logic                    last_tick;

    // Final cycle of a running period
    assign last_tick = run_reg && (count_reg == `TMC_TIMER_W'(1));

    // Next count: start beats abort, abort beats expiry
    assign count_next = start_in  ? PERIOD_CYCLES :
                        abort_in  ? '0 :
                        run_reg   ? count_reg - `TMC_TIMER_W'(1) : count_reg;
    assign run_next   = start_in || (!abort_in && run_reg && !last_tick);

    // Counter state
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            count_reg <= '0;
            run_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg   <= run_next;
        end
    end

    // Expiry is suppressed when a restart or abort lands on the last cycle
    assign done_out    = last_tick && !start_in && !abort_in;
    assign running_out = run_reg;

endmodule : tmc_period_timer

//--- design/tmc_temperature_measure_control.sv
// Purpose: Control and result registers of the on-chip temperature converter, with the compensation source mux.
// Assumes: Serial interface decodes accesses into one-cycle read and write strobes on this clock.
// Notes:   The converter code comes from the analog side and is synchronised before use.
//          Bits 6..3 of the control register are not stored and read as zero.
//          The busy interval is a fixed nominal count; the real sensor time drifts with temperature.
//          Compensation sees the clamped value; the registers keep the raw value for readback.
//          A host write of the enable bit always wins over any automatic start.
`timescale 1ns/100ps
`include "tmc_map.svh"

// Summary of operation
// - Control bit 7 shows measurement in progress
// - Writing enable 1 always starts fresh period
// - Period lasts nominal twenty milliseconds
// - Enable 0 keeps sensor off, no measurements
// - Repeat bit with enable measures back to back
// - Without repeat, measure at start-up, power-save exit
// - Power-save suspends repeated measurements
// - Select bit picks internal or host temperature
// - Result register read-only, resets to 25 degrees
// - Temperatures are 8-bit two's complement degrees
// - Compensation clamps above 89 to 89
// - Compensation clamps below -38 to -38
// - Host temperature register read-write, resets zero
module tmc_temperature_measure_control
    import tmc_pkg::*;
#(
    parameter logic [`TMC_TIMER_W-1:0] MEAS_CYCLES = `TMC_TIMER_W'(`TMC_MEAS_CYCLES)
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // Register port from the serial interface
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // Device mode
    input  wire logic       startup_in,
    input  wire logic       power_save_in,
    // Analog converter
    input  wire logic [7:0] sensor_code_in,
    output logic            sensor_enable_out,
    output logic            conv_start_out,
    // Compensation source
    output logic      [7:0] comp_temp_out
);

    // Register storage
    // Only bits 2..0 and the busy flag of the control register hold state
    logic          sensor_enable_reg;
    logic          sensor_enable_next;
    logic          repeat_conversion_enable_reg;
    logic          repeat_conversion_enable_next;
    logic          external_source_select_reg;
    logic          external_source_select_next;
    logic          conversion_active_flag_reg;
    logic          conversion_active_flag_next;
    tmc_temp_type  int_result_reg;
    tmc_temp_type  int_result_next;
    tmc_temp_type  ext_value_reg;
    tmc_temp_type  ext_value_next;
    logic [7:0]    rdata_reg;
    logic [7:0]    rdata_next;
    tmc_temp_type  comp_reg;
    tmc_temp_type  comp_next;

    // Sequencer
    // The state mirrors the timer; it keeps automatic starts out of a running period
    tmc_state_type state_reg;
    tmc_state_type state_next;
    logic          power_save_prev_reg;
    logic          start_pulse_reg;

    // Converter code synchroniser
    // Two stages per bit; only the second stage is read
    logic [7:0]    code_meta_reg;
    logic [7:0]    code_sync_reg;

    // Decode and control wires
    // Named wires keep the clocked blocks to plain register loads
    logic          hit_control;
    logic          hit_int_result;
    logic          hit_ext_value;
    logic          wr_control;
    logic          wr_ext_value;
    logic          host_start;
    logic          host_disable;
    logic          ps_exit;
    logic          auto_start;
    logic          start_meas;
    logic          abort_meas;
    logic          timer_done;
    logic [7:0]    control_view;
    tmc_temp_type  comp_source;

    // Clamp a temperature into the compensation window
    // Signed compare: an unsigned one would put every negative value above the top limit
    function automatic tmc_temp_type clamp_temp(input tmc_temp_type value);
        tmc_temp_type hi;
        tmc_temp_type lo;
        hi = tmc_temp_type'(`TMC_TEMP_MAX);
        lo = tmc_temp_type'(`TMC_TEMP_MIN);
        if (value > hi) begin
            clamp_temp = hi;
        end else if (value < lo) begin
            clamp_temp = lo;
        end else begin
            clamp_temp = value;
        end
    endfunction : clamp_temp

    // Offset compare, shared by read and write decode
    // A function so that read and write decode cannot drift apart
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
        addr_is = (addr == offset);
    endfunction : addr_is

    // Address decode
    // Only full eight-bit matches hit; every other offset is unmapped
    assign hit_control    = addr_is(reg_addr_in, `TMC_ADDR_CONTROL);
    assign hit_int_result = addr_is(reg_addr_in, `TMC_ADDR_INT_RESULT);
    assign hit_ext_value  = addr_is(reg_addr_in, `TMC_ADDR_EXT_VALUE);
    assign wr_control     = reg_wr_in && hit_control;
    assign wr_ext_value   = reg_wr_in && hit_ext_value;

    // Host-driven starts and stops
    // A restart reloads the timer instead of queueing, so the host always gets
    // a full period after its last enabling write
    assign host_start   = wr_control && reg_wdata_in[`TMC_CTRL_ENABLE_BIT];
    assign host_disable = wr_control && !reg_wdata_in[`TMC_CTRL_ENABLE_BIT];

    // Leaving power-save is seen as a falling level
    // Power-save is on this clock, so one history flop suffices; it resets to awake,
    // so no false exit follows reset
    assign ps_exit = power_save_prev_reg && !power_save_in;

    // Automatic starts need the sensor enabled and the sequencer idle
    // Waiting for idle keeps a repeat start from cutting its own period short;
    // in repeat mode the busy flag is low for exactly one cycle between periods
    assign auto_start = sensor_enable_reg && !host_disable && (state_reg == TMC_IDLE) &&
                        (startup_in || ps_exit ||
                         (repeat_conversion_enable_reg && !power_save_in));

    // A host start restarts even a running period
    // A disabling write drops the running period without a result
    assign start_meas = host_start || auto_start;
    assign abort_meas = host_disable && !host_start;

    // Period timer with the nominal busy interval
    // The count is fixed; a temperature-dependent period would need a done
    // signal from the converter, which this block does not receive
    tmc_period_timer #(
        .PERIOD_CYCLES (MEAS_CYCLES)
    ) u_period_timer (
        .clk_in      (clk_in),
        .nrst_in     (nrst_in),
        .start_in    (start_meas),
        .abort_in    (abort_meas),
        .running_out (),
        .done_out    (timer_done)
    );

    // Sequencer next state
    // Only the two one-hot codes are legal; an upset code falls back to idle
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            TMC_IDLE: begin
                if (start_meas) begin
                    state_next = TMC_MEASURE;
                end
            end
            TMC_MEASURE: begin
                if (abort_meas || (timer_done && !start_meas)) begin
                    state_next = TMC_IDLE;
                end
            end
            default: begin
                state_next = TMC_IDLE;
            end
        endcase
    end

    // Control fields: only bits 2..0 are writable
    // Bits 7..3 of a write are dropped; busy belongs to the sequencer
    assign sensor_enable_next            = wr_control ? reg_wdata_in[`TMC_CTRL_ENABLE_BIT] : sensor_enable_reg;
    assign repeat_conversion_enable_next = wr_control ? reg_wdata_in[`TMC_CTRL_REPEAT_BIT] :
                                                        repeat_conversion_enable_reg;
    assign external_source_select_next   = wr_control ? reg_wdata_in[`TMC_CTRL_SELECT_BIT] :
                                                        external_source_select_reg;

    // Busy: a start wins over a completion in the same cycle
    // so a restart on the last cycle never shows a done that no result follows;
    // an abort clears it without touching the result
    assign conversion_active_flag_next = start_meas ? 1'b1 :
                                         (timer_done || abort_meas) ? 1'b0 :
                                         conversion_active_flag_reg;

    // Result is loaded only by the converter, never by the host
    // The code is taken only at period end; the converter must hold it steady
    // for the last two cycles, as the synchroniser adds two cycles of delay
    assign int_result_next = timer_done ? tmc_temp_type'(code_sync_reg) : int_result_reg;

    // Host temperature register
    // Stored raw; clamping applies to the compensation path only
    assign ext_value_next = wr_ext_value ? tmc_temp_type'(reg_wdata_in) : ext_value_reg;

    // Readback of the control register
    // Unstored bits 6..3 read as zero
    assign control_view = {conversion_active_flag_reg,
                           4'h0,
                           sensor_enable_reg,
                           repeat_conversion_enable_reg,
                           external_source_select_reg};

    // Read data: unmapped offsets answer zero
    // Registered and held until the next read, so the serial side may
    // shift the byte out over several cycles
    assign rdata_next = !reg_rd_in     ? rdata_reg :
                        hit_control    ? control_view :
                        hit_int_result ? 8'(int_result_reg) :
                        hit_ext_value  ? 8'(ext_value_reg) : `TMC_RDATA_NONE;

    // Compensation source and clamp
    // One cycle behind the registers; the compensation path tolerates the lag
    assign comp_source = external_source_select_reg ? ext_value_reg : int_result_reg;
    assign comp_next   = clamp_temp(comp_source);

    // Converter code crosses in from the analog side; sampled every cycle, used only at period end
    // Bits are not gray coded; a word caught mid-change is harmless only because
    // the code stands still well before the period ends
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            code_meta_reg <= 8'h00;
            code_sync_reg <= 8'h00;
        end else begin
            code_meta_reg <= sensor_code_in;
            code_sync_reg <= code_meta_reg;
        end
    end

    // Sequencer state and mode history
    // The start pulse is registered so the converter sees a clean one-cycle strobe
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_reg           <= TMC_IDLE;
            power_save_prev_reg <= 1'b0;
            start_pulse_reg     <= 1'b0;
        end else begin
            state_reg           <= state_next;
            power_save_prev_reg <= power_save_in;
            start_pulse_reg     <= start_meas;
        end
    end

    // Control reset value, split into its stored fields below
    localparam logic [7:0] CTRL_RST = `TMC_RST_CONTROL;

    // Control register; the busy flag takes its reset from the readback bit
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sensor_enable_reg            <= CTRL_RST[`TMC_CTRL_ENABLE_BIT];
            repeat_conversion_enable_reg <= CTRL_RST[`TMC_CTRL_REPEAT_BIT];
            external_source_select_reg   <= CTRL_RST[`TMC_CTRL_SELECT_BIT];
            conversion_active_flag_reg   <= CTRL_RST[`TMC_CTRL_BUSY_BIT];
        end else begin
            sensor_enable_reg            <= sensor_enable_next;
            repeat_conversion_enable_reg <= repeat_conversion_enable_next;
            external_source_select_reg   <= external_source_select_next;
            conversion_active_flag_reg   <= conversion_active_flag_next;
        end
    end

    // Temperature registers
    // Result resets to 25 degrees so compensation has a sane value before any measurement
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            int_result_reg <= tmc_temp_type'(`TMC_RST_INT_RESULT);
            ext_value_reg  <= tmc_temp_type'(`TMC_RST_EXT_VALUE);
        end else begin
            int_result_reg <= int_result_next;
            ext_value_reg  <= ext_value_next;
        end
    end

    // Output registers
    // Compensation resets to the result's reset value, not to the host register
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rdata_reg <= `TMC_RDATA_NONE;
            comp_reg  <= tmc_temp_type'(`TMC_RST_INT_RESULT);
        end else begin
            rdata_reg <= rdata_next;
            comp_reg  <= comp_next;
        end
    end

    // Outputs; sensor power follows the enable bit alone
    // The sensor stays powered between periods while enabled; a write of 0 switches it off
    assign reg_rdata_out     = rdata_reg;
    assign sensor_enable_out = sensor_enable_reg;
    assign conv_start_out    = start_pulse_reg;
    assign comp_temp_out     = 8'(comp_reg);

endmodule : tmc_temperature_measure_control

//--- include/tmc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the temperature measurement control block.
// Assumes: Byte-wide registers reached at their printed offsets over the register port.
// Notes:   Definitions only; included by bare name.
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH

// Register offsets
`define TMC_ADDR_CONTROL        8'h3e
`define TMC_ADDR_INT_RESULT     8'h3f
`define TMC_ADDR_EXT_VALUE      8'h40

// Control register fields
`define TMC_CTRL_BUSY_BIT       7
`define TMC_CTRL_ENABLE_BIT     2
`define TMC_CTRL_REPEAT_BIT     1
`define TMC_CTRL_SELECT_BIT     0

// Reset values
`define TMC_RST_CONTROL         8'h00
`define TMC_RST_INT_RESULT      8'h19
`define TMC_RST_EXT_VALUE       8'h00
`define TMC_RDATA_NONE          8'h00

// Compensation window limits, two's complement whole degrees
`define TMC_TEMP_MAX            8'h59
`define TMC_TEMP_MIN            8'hda

// Timing: nominal measurement period and its cycle count at the 125 MHz clock
`define TMC_CLK_HZ              64'd125000000
`define TMC_MEAS_PERIOD_MS      64'd20
`define TMC_MEAS_CYCLES         ((`TMC_MEAS_PERIOD_MS * `TMC_CLK_HZ) / 64'd1000)
`define TMC_TIMER_W             22

`endif

//--- include/tmc_pkg.sv
// Purpose: Types shared by the temperature measurement control design files.
// Assumes: Constants come from tmc_map.svh.
// Notes:   State codes are one-hot.
package tmc_pkg;

    // Temperature in two's complement whole degrees
    typedef logic signed [7:0] tmc_temp_type;

    // Measurement sequencer states
    typedef enum logic [1:0] {
        TMC_IDLE    = 2'b01,
        TMC_MEASURE = 2'b10
    } tmc_state_type;

endpackage : tmc_pkg

//--- tb/tmc_host_model.sv
// Purpose: Host side of the register port, issuing one-cycle strobes.
// Assumes: Strobes change only at falling edges.
// Notes:   One idle cycle between requests; released lines show inverted values.
`timescale 1ns/100ps
module tmc_host_model (
    // Clock
    input  wire logic       clk_in,
    // Register port
    input  wire logic [7:0] reg_rdata_in,
    output logic      [7:0] reg_addr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_wr_out,
    output logic            reg_rd_out
);
    // Idle port at time zero
    initial begin
        reg_addr_out  = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out    = 1'b0;
        reg_rd_out    = 1'b0;
    end
    // Temperatures go out as two's complement bytes
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_wr_out    = 1'b1;
        @(negedge clk_in);
        reg_wr_out    = 1'b0;
        reg_addr_out  = ~a;
        reg_wdata_out = ~d;
    endtask : wr_reg
    // Data taken one cycle after the strobe edge
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_rd_out   = 1'b1;
        @(negedge clk_in);
        d            = reg_rdata_in;
        reg_rd_out   = 1'b0;
        reg_addr_out = ~a;
    endtask : rd_reg
endmodule : tmc_host_model

//--- tb/tmc_properties.sv
// Purpose: Concurrent checks on the ports of the temperature measurement control block.
// Assumes: One clock domain; synchronous active-low reset.
// Notes:   Bound to the design top; spacing counter saturates instead of wrapping.
`timescale 1ns/100ps
module tmc_properties #(
    parameter logic [21:0] MEAS_CYCLES = 22'd20
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // Register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [7:0] reg_rdata_out,
    // Mode and outputs
    input  wire logic       startup_in,
    input  wire logic       power_save_in,
    input  wire logic       sensor_enable_out,
    input  wire logic       conv_start_out,
    input  wire logic [7:0] comp_temp_out
);
    logic        sel_q;
    logic [23:0] since_q;
    wire         host_start = reg_wr_in && reg_addr_in == 8'h3e && reg_wdata_in[2];
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Select copy and cycles since last start; saturating so long idles never wrap into a false early start
    always_ff @(posedge clk_in) begin
        sel_q   <= !nrst_in ? 1'b0 : (reg_wr_in && reg_addr_in == 8'h3e) ? reg_wdata_in[0] : sel_q;
        since_q <= !nrst_in ? 24'hffffff : conv_start_out ? 24'd1 :
                   (since_q == 24'hffffff) ? since_q : since_q + 24'd1;
    end
    function automatic logic [7:0] clamp8(input logic [7:0] v);
        if ($signed(v) > $signed(8'h59)) return 8'h59;
        if ($signed(v) < $signed(8'hda)) return 8'hda;
        return v;
    endfunction : clamp8
    sequence s_host_start;
        host_start;
    endsequence
    sequence s_ext_wr;
        reg_wr_in && reg_addr_in == 8'h40;
    endsequence
    chk_enable_follows_write: assert property (reg_wr_in && reg_addr_in == 8'h3e |=>
        sensor_enable_out == $past(reg_wdata_in[2])) else $error("sensor enable differs from written bit");
    chk_start_on_write: assert property (s_host_start |=> conv_start_out)
        else $error("no start pulse after enabling write");
    chk_start_needs_enable: assert property (conv_start_out |-> sensor_enable_out)
        else $error("start pulse while sensor disabled");
    chk_comp_in_range: assert property (!($signed(comp_temp_out) > $signed(8'h59))
        && !($signed(comp_temp_out) < $signed(8'hda))) else $error("compensation value outside window");
    chk_ext_comp_clamp: assert property (s_ext_wr ##0 sel_q ##1 !reg_wr_in |=>
        comp_temp_out == clamp8($past(reg_wdata_in, 2))) else $error("host temperature not clamped into output");
    chk_ext_read_back: assert property (s_ext_wr ##1 !reg_wr_in ##1 (reg_rd_in && reg_addr_in == 8'h40) |=>
        reg_rdata_out == $past(reg_wdata_in, 3)) else $error("host temperature read back differs");
    chk_auto_start_spacing: assert property (conv_start_out && !$past(host_start) |->
        since_q > {2'b00, MEAS_CYCLES}) else $error("automatic start before period ended");
    chk_power_save_hold: assert property (conv_start_out && $past(power_save_in) && !$past(startup_in) |->
        $past(host_start)) else $error("automatic start during power save");
endmodule : tmc_properties

bind tmc_temperature_measure_control tmc_properties #(.MEAS_CYCLES(MEAS_CYCLES)) tmc_properties_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .startup_in(startup_in),
    .power_save_in(power_save_in), .sensor_enable_out(sensor_enable_out), .conv_start_out(conv_start_out),
    .comp_temp_out(comp_temp_out));

//--- tb/tmc_temperature_measure_control_test.sv
// Purpose: Self-checking bench for the temperature measurement control block.
// Assumes: Inputs change at falling edges; short measurement period.
// Notes:   Start pulses are counted at falling edges.
`timescale 1ns/100ps
module tmc_temperature_measure_control_test;
    localparam int M = 20;
    logic       clk_in = 1'b0, nrst_in = 1'b0, startup_in = 1'b0, power_save_in = 1'b0;
    logic [7:0] sensor_code_in = 8'h00, reg_addr_in, reg_wdata_in, reg_rdata_out, comp_temp_out, rd;
    logic       reg_wr_in, reg_rd_in, sensor_enable_out, conv_start_out;
    int         miscompares = 0, num_checks = 0, pulses = 0, p;
    logic [7:0] tv [7] = '{8'h7f, 8'h59, 8'h5a, 8'hda, 8'hd9, 8'h80, 8'hf0};
    logic [7:0] te [7] = '{8'h59, 8'h59, 8'h59, 8'hda, 8'hda, 8'hda, 8'hf0};
    // Clock and start-pulse counter
    always #4 clk_in = ~clk_in;
    always @(negedge clk_in) if (conv_start_out === 1'b1) pulses++;
    tmc_temperature_measure_control #(.MEAS_CYCLES(22'd20)) tmc_temperature_measure_control_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .startup_in(startup_in),
        .power_save_in(power_save_in), .sensor_code_in(sensor_code_in), .sensor_enable_out(sensor_enable_out),
        .conv_start_out(conv_start_out), .comp_temp_out(comp_temp_out));
    tmc_host_model tmc_host_model_i (.clk_in(clk_in), .reg_rdata_in(reg_rdata_out), .reg_addr_out(reg_addr_in),
        .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task cyc(input int n); repeat (n) @(negedge clk_in); endtask : cyc
    task wr(input logic [7:0] a, input logic [7:0] d); tmc_host_model_i.wr_reg(a, d); endtask : wr
    task rdchk(input logic [7:0] a, input logic [7:0] e); tmc_host_model_i.rd_reg(a, rd); check(rd, e); endtask : rdchk
    task pulse_count(input int n, input int win); p = pulses; cyc(win); check(8'(pulses - p), 8'(n)); endtask : pulse_count
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    // Reset values and a refused write to the result
    task t_defaults;
        check(comp_temp_out, 8'h19);
        rdchk(8'h3e, 8'h00);
        rdchk(8'h40, 8'h00);
        wr(8'h3f, 8'h55);
        rdchk(8'h3f, 8'h19);
    endtask : t_defaults
    // Restarted single period: busy just before end, clear just after
    task t_single;
        sensor_code_in = 8'he7;
        wr(8'h3e, 8'h04);
        check({7'h0, sensor_enable_out}, 8'h01);
        cyc(6);
        wr(8'h3e, 8'h04);
        rdchk(8'h3e, 8'h84);
        cyc(M - 5);
        rdchk(8'h3e, 8'h84);
        rdchk(8'h3e, 8'h04);
        rdchk(8'h3f, 8'he7);
        check(comp_temp_out, 8'he7);
    endtask : t_single
    // Host source with clamping at both ends
    task t_clamp;
        wr(8'h3e, 8'h01);
        for (int i = 0; i < 7; i++) begin
            wr(8'h40, tv[i]);
            cyc(1);
            check(comp_temp_out, te[i]);
        end
        wr(8'h40, 8'h25);
        rdchk(8'h40, 8'h25);
        wr(8'h3e, 8'h00);
        cyc(1);
        check(comp_temp_out, 8'he7);
    endtask : t_clamp
    // Abort mid-period, then no start while disabled
    task t_abort;
        sensor_code_in = 8'h5a;
        wr(8'h3e, 8'h04);
        wr(8'h3e, 8'h00);
        rdchk(8'h3e, 8'h00);
        cyc(M);
        rdchk(8'h3f, 8'he7);
        startup_in = 1'b1;
        cyc(1);
        startup_in = 1'b0;
        pulse_count(0, M);
    endtask : t_abort
    // Back-to-back periods, suspension and resume
    task t_repeat;
        sensor_code_in = 8'h10;
        p = pulses;
        wr(8'h3e, 8'h06);
        cyc(2 * M - 2);
        check(8'(pulses - p), 8'h02);
        power_save_in = 1'b1;
        pulse_count(0, 2 * M);
        power_save_in = 1'b0;
        pulse_count(1, 3);
        wr(8'h3e, 8'h00);
        rdchk(8'h3f, 8'h10);
    endtask : t_repeat
    // Start-up start and power-save exit start, both without repeat
    task t_startup;
        wr(8'h3e, 8'h04);
        cyc(M + 2);
        startup_in = 1'b1;
        p = pulses;
        cyc(1);
        startup_in = 1'b0;
        cyc(2);
        check(8'(pulses - p), 8'h01);
        pulse_count(0, M + 4);
        power_save_in = 1'b1;
        cyc(2);
        power_save_in = 1'b0;
        pulse_count(1, 3);
    endtask : t_startup
    // Main sequence
    initial begin
        cyc(12);
        nrst_in = 1'b1;
        cyc(1);
        t_defaults();
        t_single();
        t_clamp();
        t_abort();
        t_repeat();
        t_startup();
        test_done();
    end
    // Hang guard
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
endmodule : tmc_temperature_measure_control_test
